// ### pkg/sil_pkg.sv
// Shared constants and types of the sensor interrupt logic
package sil_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INT_CFG  = 8'h00;
  localparam logic [7:0] OFS_INT_SRC  = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_FIFO_CFG = 8'h0c;
  localparam logic [7:0] OFS_WIN_LSB  = 8'h10;
  localparam logic [7:0] OFS_WIN_MSB  = 8'h14;
  localparam logic [7:0] OFS_WIN_RNG  = 8'h18;
  localparam logic [7:0] OFS_WIN_CFG  = 8'h1c;
  localparam logic [7:0] OFS_FIFO_LVL = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_LATCHED = 0;  // 1 latched, 0 pulsed
  localparam int CFG_POL_HI  = 1;  // 1 active high
  localparam int CFG_DRIVE   = 2;  // irq_drive_type: 1 open-drain
  localparam int CFG_PIN_EN  = 3;
  localparam int SRC_DRDY    = 0;  // Also status bit positions
  localparam int SRC_FULL    = 1;
  localparam int SRC_THS     = 2;
  localparam int SRC_WIN     = 3;
  localparam int STAT_POR    = 4;
  localparam int FCFG_THR_LO = 0;  // Threshold [4:0]
  localparam int FCFG_SEL_LO = 5;  // Frame select [6:5]
  localparam int WCFG_REF16  = 0;
  localparam int WCFG_LIM_LO = 4;  // Count limit [7:4]

  // ----------------------------------------------------------------
  // Frame selections and capacities
  // ----------------------------------------------------------------
  localparam logic [1:0] FSEL_OFF = 2'h0;
  localparam logic [1:0] FSEL_PT  = 2'h3;
  localparam logic [5:0] CAP_PT   = 6'h10;  // 16 frames
  localparam logic [5:0] CAP_ONE  = 6'h20;  // 32 frames

  // ----------------------------------------------------------------
  // Pin timing, nanoseconds and cycles at 50 MHz
  // ----------------------------------------------------------------
  localparam int CLK_MHZ   = 50;
  localparam int PULSE_NS  = 1000;
  localparam int GAP_NS    = 2000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC   = (GAP_NS * CLK_MHZ + 999) / 1000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {PIN_IDLE, PIN_ACTIVE, PIN_GAP} sil_pin_t;

endpackage

// ### rtl/sil_top.sv
// Interrupt generation, pin timing and AXI4-Lite registers of the sensor
//
// Overview of operation
// - Full flag when level hits 16 or 32
// - Threshold flag when level at or above threshold
// - FIFO flags set at data ready, held
// - No FIFO flags when disabled; reads harmless
// - Burst read drop releases flag at burst end
// - Data ready flag when new results land
// - Seventeen-bit reference from three register parts
// - Eight-bit unsigned margin around reference
// - Alarm after count of strict out-of-window samples
// - Alarm repeats on each further outside sample
// - Power-up flag set at reset, read clears
// - Power-up event never drives the pin
// - Per-source enables ORed onto enabled pin
// - Pin polarity, drive type, pulsed or latched
// - Pulsed: fixed pulse per rising condition, gap
// - Latched: active while condition true, gap
// - Latched release rules per source, drdy continues
// - Flush kills FIFO and window interrupts, disable kills FIFO ones only
// - Threshold rewrite drops pin, recomputes status, regaps
// - Status bits clear by reads, and by flush, disable or threshold rewrite as described
// - Threshold events continue during FIFO reads
// - Gap may shorten only with FIFO or window sources enabled
// - Power-up source has no enable bit
// - Threshold zero disables detection
`timescale 1ns/1ps
module sil_top
  import sil_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int GAP_CYCLES   = GAP_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        meas_done,
  input  wire logic [16:0] pressure,
  input  wire logic [5:0]  fifo_level,
  input  wire logic        fifo_burst,
  input  wire logic        fifo_flush,
  output logic             irq_out,
  output logic             irq_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        awrdy;
    logic        wrdy;
    logic [7:0]  awaddr;
    logic [7:0]  wdata;
    logic        wlane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  cfg;
    logic [3:0]  src;
    logic [4:0]  thr;
    logic [1:0]  fsel;
    logic [16:0] wref;
    logic [7:0]  wrng;
    logic [3:0]  wlim;
    logic        full_act;
    logic        ths_act;
    logic [4:0]  stat;
    logic [3:0]  wcnt;
    logic        pend;
    sil_pin_t    pin;
    logic [15:0] tcnt;
    logic        irq_out;
    logic        irq_oe;
  } sil_state_t;

  sil_state_t s_q;
  sil_state_t s_d;

  // Scratch terms of the next-state logic
  logic        wr_go;
  logic        rd_go;
  logic        rd_stat;
  logic        thr_wr;
  logic        flush;
  logic        f_on;
  logic [5:0]  cap;
  logic [5:0]  thr_eff;
  logic        full_cond;
  logic        ths_cond;
  logic        outside;
  logic [3:0]  wcnt_n;
  logic [3:0]  lim_eff;
  logic        win_evt;
  logic        lreq;
  logic        preq;
  logic        lvl;
  logic [17:0] hi_bnd;
  logic [17:0] p_plus;
  logic [31:0] rd_val;
  logic        rd_hit;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Read data mux, unmapped addresses answer SLVERR
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      OFS_INT_CFG:  rd_val[3:0] = s_q.cfg;
      OFS_INT_SRC:  rd_val[3:0] = s_q.src;
      OFS_INT_STAT: rd_val[4:0] = s_q.stat;
      OFS_FIFO_CFG: rd_val[6:0] = {s_q.fsel, s_q.thr};
      OFS_WIN_LSB:  rd_val[7:0] = s_q.wref[7:0];
      OFS_WIN_MSB:  rd_val[7:0] = s_q.wref[15:8];
      OFS_WIN_RNG:  rd_val[7:0] = s_q.wrng;
      OFS_WIN_CFG:  rd_val[7:0] = {s_q.wlim, 3'h0, s_q.wref[16]};
      OFS_FIFO_LVL: rd_val[5:0] = fifo_level;
      default:      rd_hit = 1'b0;
    endcase

    // Write channel: address and data taken in either order
    if (s_q.awrdy && s_axi_awvalid) begin
      s_d.awrdy  = 1'b0;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_q.wrdy && s_axi_wvalid) begin
      s_d.wrdy   = 1'b0;
      s_d.wdata  = s_axi_wdata[7:0];
      s_d.wlane0 = s_axi_wstrb[0];
    end
    wr_go = !s_q.awrdy && !s_q.wrdy && !s_q.bvalid;
    thr_wr = 1'b0;
    flush = fifo_flush;
    if (wr_go) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      if (s_q.wlane0) begin
        case (s_q.awaddr)
          OFS_INT_CFG:  s_d.cfg = s_q.wdata[3:0];
          OFS_INT_SRC:  s_d.src = s_q.wdata[3:0];
          OFS_FIFO_CFG: begin
            s_d.thr  = s_q.wdata[FCFG_SEL_LO-1:FCFG_THR_LO];
            s_d.fsel = s_q.wdata[FCFG_SEL_LO+1:FCFG_SEL_LO];
            thr_wr   = 1'b1;
            if (s_d.fsel != s_q.fsel) begin
              flush = 1'b1;
            end
          end
          OFS_WIN_LSB:  s_d.wref[7:0]  = s_q.wdata;
          OFS_WIN_MSB:  s_d.wref[15:8] = s_q.wdata;
          OFS_WIN_RNG:  s_d.wrng       = s_q.wdata;
          OFS_WIN_CFG:  begin
            s_d.wref[16] = s_q.wdata[WCFG_REF16];
            s_d.wlim     = s_q.wdata[WCFG_LIM_LO+3:WCFG_LIM_LO];
          end
          OFS_INT_STAT, OFS_FIFO_LVL: ;
          default: s_d.bresp = RESP_SLVERR;
        endcase
      end else if (!rd_hit && 1'b0) begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awrdy  = 1'b1;
      s_d.wrdy   = 1'b1;
    end

    // Read channel
    rd_go   = s_q.arrdy && s_axi_arvalid;
    rd_stat = rd_go && (s_axi_araddr == OFS_INT_STAT);
    if (rd_go) begin
      s_d.arrdy  = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_val;
      s_d.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arrdy  = 1'b1;
    end

    // FIFO conditions with the settings now in force
    f_on      = (s_d.fsel != FSEL_OFF);
    cap       = (s_d.fsel == FSEL_PT) ? CAP_PT : CAP_ONE;
    thr_eff   = (s_d.fsel == FSEL_PT) ? {2'h0, s_d.thr[3:0]}
                                      : {1'b0, s_d.thr};
    full_cond = f_on && (fifo_level == cap);
    ths_cond  = f_on && (thr_eff != 6'h00)
                && (fifo_level >= thr_eff);

    // Set at data ready, release once gone and no burst runs
    if (meas_done && full_cond) begin
      s_d.full_act = 1'b1;
    end else if (!full_cond && !fifo_burst) begin
      s_d.full_act = 1'b0;
    end
    if (meas_done && ths_cond) begin
      s_d.ths_act = 1'b1;
    end else if (!ths_cond && !fifo_burst) begin
      s_d.ths_act = 1'b0;
    end
    if (thr_wr) begin
      s_d.ths_act = ths_cond;
    end

    // Window check on each new sample
    hi_bnd  = {1'b0, s_q.wref} + {10'h000, s_q.wrng};
    p_plus  = {1'b0, pressure} + {10'h000, s_q.wrng};
    outside = ({1'b0, pressure} > hi_bnd)
              || (p_plus < {1'b0, s_q.wref});
    lim_eff = (s_q.wlim == 4'h0) ? 4'h1 : s_q.wlim;
    wcnt_n  = (s_q.wcnt == 4'hf) ? s_q.wcnt : s_q.wcnt + 4'h1;
    win_evt = meas_done && outside && (wcnt_n >= lim_eff);
    if (meas_done) begin
      s_d.wcnt = outside ? wcnt_n : 4'h0;
    end

    // Status: hardware set wins over the read clear
    s_d.stat[SRC_FULL] = s_d.full_act
                         || (s_q.stat[SRC_FULL] && !rd_stat);
    s_d.stat[SRC_THS]  = s_d.ths_act
                         || (s_q.stat[SRC_THS] && !rd_stat && !thr_wr);
    s_d.stat[SRC_DRDY] = meas_done
                         || (s_q.stat[SRC_DRDY] && !rd_stat);
    s_d.stat[SRC_WIN]  = win_evt
                         || (s_q.stat[SRC_WIN] && !rd_stat);
    s_d.stat[STAT_POR] = s_q.stat[STAT_POR] && !rd_stat;

    // Flush or disable wipes FIFO state at once; only a flush also wipes window state
    if (flush || !f_on) begin
      s_d.full_act       = 1'b0;
      s_d.ths_act        = 1'b0;
      s_d.stat[SRC_FULL] = 1'b0;
      s_d.stat[SRC_THS]  = 1'b0;
    end
    if (flush) begin
      s_d.stat[SRC_WIN] = 1'b0;
      s_d.wcnt          = 4'h0;
    end

    // Enabled sources only; power-up is never among them
    lreq = (s_q.src[SRC_FULL] && s_d.full_act)
        || (s_q.src[SRC_THS]  && s_d.ths_act)
        || (s_q.src[SRC_DRDY] && s_d.stat[SRC_DRDY])
        || (s_q.src[SRC_WIN]  && s_d.stat[SRC_WIN]);
    preq = (s_q.src[SRC_FULL] && s_d.full_act && !s_q.full_act)
        || (s_q.src[SRC_THS]  && s_d.ths_act && !s_q.ths_act)
        || (s_q.src[SRC_DRDY] && meas_done)
        || (s_q.src[SRC_WIN]  && win_evt);
    // A pulse request only counts in pulsed mode, and none outlives a
    // write of zero to the enables, so a mode change starts clean
    if (preq && !s_q.cfg[CFG_LATCHED]) begin
      s_d.pend = 1'b1;
    end
    if (s_q.src == 4'h0) begin
      s_d.pend = 1'b0;
    end

    // Pin timing
    case (s_q.pin)
      PIN_IDLE: begin
        if (s_q.cfg[CFG_LATCHED] ? lreq : s_d.pend) begin
          s_d.pin  = PIN_ACTIVE;
          s_d.pend = 1'b0;
          s_d.tcnt = 16'(PULSE_CYCLES - 1);
        end
      end
      PIN_ACTIVE: begin
        if (s_q.cfg[CFG_LATCHED] ? !lreq
                                 : (s_q.tcnt == 16'h0000)) begin
          s_d.pin  = PIN_GAP;
          s_d.tcnt = 16'(GAP_CYCLES - 1);
        end else if (s_q.tcnt != 16'h0000) begin
          s_d.tcnt = s_q.tcnt - 16'h0001;
        end
      end
      PIN_GAP: begin
        if (s_q.tcnt == 16'h0000) begin
          s_d.pin = PIN_IDLE;
        end else begin
          s_d.tcnt = s_q.tcnt - 16'h0001;
        end
      end
      default: s_d.pin = PIN_IDLE;
    endcase
    if (thr_wr && s_q.pin == PIN_ACTIVE) begin
      s_d.pin  = PIN_GAP;
      s_d.tcnt = 16'(GAP_CYCLES - 1);
    end
    // A flush with FIFO or window sources enabled cuts pulse or gap short; a FIFO that merely stays off
    // must not, or a window alarm could never reach the pin
    if (flush && s_q.pin != PIN_IDLE
        && (s_q.src[SRC_FULL] || s_q.src[SRC_THS] || s_q.src[SRC_WIN])) begin
      s_d.pin  = PIN_IDLE;
      s_d.pend = 1'b0;
    end
    if (!s_q.cfg[CFG_PIN_EN]) begin
      s_d.pin  = PIN_IDLE;
      s_d.pend = 1'b0;
    end

    // Pad drive from polarity and drive type
    lvl = (s_d.pin == PIN_ACTIVE) ~^ s_q.cfg[CFG_POL_HI];
    if (!s_q.cfg[CFG_PIN_EN]) begin
      s_d.irq_out = 1'b0;
      s_d.irq_oe  = 1'b0;
    end else if (s_q.cfg[CFG_DRIVE]) begin
      s_d.irq_out = 1'b0;
      s_d.irq_oe  = !lvl;
    end else begin
      s_d.irq_out = lvl;
      s_d.irq_oe  = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q                <= '0;
      s_q.awrdy          <= 1'b1;
      s_q.wrdy           <= 1'b1;
      s_q.arrdy          <= 1'b1;
      s_q.pin            <= PIN_IDLE;
      s_q.stat[STAT_POR] <= 1'b1;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = s_q.awrdy;
  assign s_axi_wready  = s_q.wrdy;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arrdy;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign irq_out       = s_q.irq_out;
  assign irq_oe        = s_q.irq_oe;

endmodule

// ### verif/sil_host_pin.sv
// Host-side model of the interrupt line as seen by the processor
`timescale 1ns/1ps
module sil_host_pin (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic irq_out,
  input  wire logic irq_oe,
  input  wire logic pull_up,
  input  wire logic act_hi,
  output logic      pin,
  output logic      active,
  output int        n_act,
  output int        last_len
);
  logic last_q;
  int   run_q;

  // Released line: pull-up level, else the inverse of the last level
  always_comb pin = irq_oe ? irq_out : (pull_up ? 1'b1 : ~last_q);
  always_comb active = (irq_oe || pull_up) && (pin == act_hi);

  // Count assertions and measure the length of the last one
  always_ff @(posedge ref_clk) begin
    last_q <= pin;
    if (!rstn) begin
      n_act <= 0;
      run_q <= 0;
      last_len <= 0;
    end else if (active) begin
      if (run_q == 0) n_act <= n_act + 1;
      run_q <= run_q + 1;
    end else begin
      if (run_q != 0) last_len <= run_q;
      run_q <= 0;
    end
  end
endmodule

// ### verif/sil_top_assertions.sv
// Concurrent checks on the ports of the interrupt block
`timescale 1ns/1ps
module sil_top_assertions
  import sil_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int GAP_CYCLES   = GAP_CYC
) (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq_out,
  input wire logic        irq_oe
);
  // ----------------------------------------------------------------
  // Config mirror, pin activity counters and properties
  // ----------------------------------------------------------------
  logic [7:0] a_q;
  logic [3:0] d_q, cfg_q, src_q;
  logic       act;
  int         run_q, gap_q;

  // Track pin config and source enables from completed writes
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg_q <= 4'h0;
      src_q <= 4'h0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      if (a_q == OFS_INT_CFG) cfg_q <= d_q;
      if (a_q == OFS_INT_SRC) src_q <= d_q;
    end
    if (s_axi_awvalid && s_axi_awready) a_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) d_q <= s_axi_wdata[3:0];
  end

  assign act = irq_oe && (irq_out == cfg_q[CFG_POL_HI]);

  // Length of the current assertion and of the current gap
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      run_q <= 0;
      gap_q <= 1000;
    end else if (act) begin
      run_q <= run_q + 1;
      gap_q <= 0;
    end else begin
      run_q <= 0;
      if (gap_q < 1000) gap_q <= gap_q + 1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_rd_give; s_axi_rvalid && !s_axi_arready; endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  property p_reset_idle;
    disable iff (1'b0) !rstn |=> !irq_oe && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  property p_rd_answer; s_rd_take |=> s_rd_give; endproperty
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_wr_answer; s_wr_take |-> ##[1:2] s_axi_bvalid; endproperty
  property p_pulse_max;
    act && !cfg_q[CFG_LATCHED] |-> run_q < PULSE_CYCLES;
  endproperty
  property p_gap;
    $rose(act) && src_q[2:1] == 2'h0 |-> gap_q >= GAP_CYCLES;
  endproperty
  property p_drive;
    !s_axi_bvalid && !cfg_q[CFG_DRIVE] |-> irq_oe == cfg_q[CFG_PIN_EN];
  endproperty

  a_reset_idle: assert property (p_reset_idle)
    else $error("pin or bus busy after reset");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer missing");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data dropped early");
  a_wr_hold: assert property (p_wr_hold)
    else $error("write response dropped early");
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response missing");
  a_pulse_max: assert property (p_pulse_max)
    else $error("pulse too long");
  a_gap: assert property (p_gap)
    else $error("inactive gap too short");
  a_drive: assert property (p_drive)
    else $error("pin enable not followed");
endmodule

bind sil_top sil_top_assertions #(
  .PULSE_CYCLES(PULSE_CYCLES), .GAP_CYCLES(GAP_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq_out(irq_out), .irq_oe(irq_oe));

// ### verif/tb.sv
// Self-checking bench of the interrupt block over its register bus
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb
  import sil_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals, design, host model, bus tasks and tests
  // ----------------------------------------------------------------
  localparam int PC = 3;
  localparam int GC = 4;
  logic        ref_clk, rstn = 1'b0;
  logic [7:0]  aw_a = 8'h0, ar_a = 8'h0;
  logic [31:0] w_d = 32'h0, r_d;
  logic        aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0;
  logic        r_rdy = 1'b0, aw_r, w_r, b_v, ar_r, r_v;
  logic [1:0]  b_resp, r_resp;
  logic        meas_done = 1'b0, fifo_burst = 1'b0, fifo_flush = 1'b0;
  logic [16:0] pressure = 17'h0;
  logic [5:0]  fifo_level = 6'h0;
  logic        irq_out, irq_oe, active, pull_up = 1'b0, act_hi = 1'b0;
  int          n_act, last_len, k, err_count = 0, num_checks = 0, cyc = 0;
  logic [7:0]  fc[6] = '{8'h64, 8'h64, 8'h44, 8'h44, 8'h60, 8'h00};
  logic [5:0]  fl[6] = '{6'd4, 6'd15, 6'd31, 6'd32, 6'd5, 6'd32};
  logic [7:0]  fx[6] = '{8'h05, 8'h05, 8'h05, 8'h07, 8'h01, 8'h01};
  logic [16:0] wp[7] = '{17'h17bb0, 17'h17bb1, 17'h17b4b, 17'h17b4c,
                         17'h17b4b, 17'h1ffff, 17'h00000};
  logic [7:0]  wx[7] = '{8'h01, 8'h01, 8'h09, 8'h01, 8'h01, 8'h09, 8'h09};

  sil_top #(.PULSE_CYCLES(PC), .GAP_CYCLES(GC)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .ce(1'b1), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_rdy),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_rdy), .meas_done(meas_done), .pressure(pressure),
    .fifo_level(fifo_level), .fifo_burst(fifo_burst),
    .fifo_flush(fifo_flush), .irq_out(irq_out), .irq_oe(irq_oe));

  sil_host_pin u_host (
    .ref_clk(ref_clk), .rstn(rstn), .irq_out(irq_out), .irq_oe(irq_oe),
    .pull_up(pull_up), .act_hi(act_hi), .pin(), .active(active),
    .n_act(n_act), .last_len(last_len));

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Register write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    aw_a <= a;
    w_d <= {24'h0, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'b1;
    do @(posedge ref_clk); while (!(aw_r && w_r));
    aw_v <= 1'b0;
    w_v <= 1'b0;
    do @(posedge ref_clk); while (!b_v);
    b_rdy <= 1'b0;
    `CHK(b_resp, a > OFS_FIFO_LVL ? RESP_SLVERR : RESP_OKAY)
  endtask

  // Register read compared with response and data
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_rdy <= 1'b1;
    do @(posedge ref_clk); while (!ar_r);
    ar_v <= 1'b0;
    do @(posedge ref_clk); while (!r_v);
    r_rdy <= 1'b0;
    `CHK({r_resp, r_d}, {a > OFS_FIFO_LVL ? RESP_SLVERR : RESP_OKAY, 24'h0, e})
  endtask

  task automatic meas(input logic [16:0] p);
    @(posedge ref_clk);
    meas_done <= 1'b1;
    pressure <= p;
    @(posedge ref_clk);
    meas_done <= 1'b0;
  endtask

  // Host procedure for a pin mode change
  task automatic mode(input logic [7:0] c, input logic [7:0] s);
    wr(OFS_INT_SRC, 8'h00);
    rd(OFS_INT_STAT, s);
    wr(OFS_INT_CFG, c);
    act_hi <= c[CFG_POL_HI];
    pull_up <= c[CFG_DRIVE];
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    wt(6);
    rstn <= 1'b1;
    rd(OFS_INT_STAT, 8'h10);
    rd(OFS_INT_STAT, 8'h00);
    rd(8'h24, 8'h00);
    wr(8'h30, 8'h01);
    `CHK(irq_oe, 1'b0);
    $display("reset test done");
    mode(8'h0b, 8'h00);
    wr(OFS_INT_SRC, 8'h01);
    meas(17'h0);
    wt(3);
    `CHK(active, 1'b1);
    meas(17'h0);
    wt(GC + 2);
    `CHK(n_act, 1);
    rd(OFS_INT_STAT, 8'h01);
    wt(3);
    `CHK(active, 1'b0);
    $display("latched test done");
    for (int i = 0; i < 2; i++) begin
      mode(i ? 8'h0c : 8'h0a, i ? 8'h01 : 8'h00);
      wr(OFS_INT_SRC, 8'h01);
      k = n_act;
      meas(17'h0);
      wt(PC + GC + 4);
      `CHK(n_act, k + 1);
      `CHK(last_len, PC);
    end
    $display("pulsed test done");
    mode(8'h0b, 8'h01);
    wr(OFS_INT_SRC, 8'h07);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_FIFO_CFG, fc[i]);
      fifo_level <= fl[i];
      meas(17'h0);
      rd(OFS_INT_STAT, fx[i]);
    end
    wr(OFS_FIFO_CFG, 8'h64);
    fifo_level <= 6'd16;
    meas(17'h0);
    wt(3);
    `CHK(active, 1'b1);
    rd(OFS_FIFO_LVL, 8'h10);
    rd(OFS_INT_STAT, 8'h07);
    rd(OFS_INT_STAT, 8'h06);
    fifo_burst <= 1'b1;
    fifo_level <= 6'd2;
    wt(4);
    `CHK(active, 1'b1);
    fifo_burst <= 1'b0;
    wt(4);
    `CHK(active, 1'b0);
    rd(OFS_INT_STAT, 8'h06);
    rd(OFS_INT_STAT, 8'h00);
    $display("fifo test done");
    wr(OFS_INT_SRC, 8'h06);
    fifo_level <= 6'd16;
    meas(17'h0);
    wt(3);
    `CHK(active, 1'b1);
    fifo_flush <= 1'b1;
    fifo_level <= 6'd0;
    wt(1);
    fifo_flush <= 1'b0;
    wt(3);
    `CHK(active, 1'b0);
    rd(OFS_INT_STAT, 8'h01);
    wr(OFS_INT_SRC, 8'h04);
    fifo_level <= 6'd8;
    meas(17'h0);
    wt(3);
    `CHK(active, 1'b1);
    wr(OFS_FIFO_CFG, 8'h65);
    wt(1);
    `CHK(active, 1'b0);
    wt(GC + 3);
    `CHK(active, 1'b1);
    $display("flush and threshold test done");
    wr(OFS_INT_SRC, 8'h08);
    fifo_level <= 6'd0;
    wr(OFS_FIFO_CFG, 8'h00);
    rd(OFS_INT_STAT, 8'h01);
    wr(OFS_WIN_LSB, 8'h7e);
    wr(OFS_WIN_MSB, 8'h7b);
    wr(OFS_WIN_RNG, 8'h32);
    wr(OFS_WIN_CFG, 8'h21);
    for (int i = 0; i < 7; i++) begin
      meas(wp[i]);
      rd(OFS_INT_STAT, wx[i]);
    end
    meas(17'h0);
    wt(GC + 2);
    `CHK(active, 1'b1);
    $display("window test done");
    end_of_test();
  end
endmodule
